// File: mcsr_regs.sv
`timescale 1ns/1ps
module mcsr_regs
   import mcsr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Dword config access
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   // Read issue and completion per class
   input wire logic rd_issue_i,
   input wire logic [1:0] rd_issue_class_i,
   input wire logic rd_done_i,
   input wire logic [1:0] rd_done_class_i,
   output logic [2:0] rd_credit_avail_o,
   // Write credit use
   input wire logic [4:0] wr_credits_free_i,
   output logic [2:0] wr_grant_ok_o,
   // Scrub and memory test logging
   input wire logic scrub_issued_i,
   input wire logic [15:0] scrub_row_i,
   input wire logic [13:0] scrub_col_i,
   input wire logic [1:0] scrub_dimm_i,
   input wire logic [1:0] scrub_rank_i,
   input wire logic [3:0] scrub_bank_i,
   input wire logic test_error_i,
   input wire logic test_running_i,
   input wire logic test_complete_i,
   output logic [29:0] next_scrub_low_o,
   output logic [9:0] next_scrub_high_o
);

   typedef struct packed {
      logic [4:0] crit_rd;
      logic [4:0] high_rd;
      logic [4:0] norm_rd;
      logic [4:0] cnt_crit;
      logic [4:0] cnt_high;
      logic [4:0] cnt_norm;
      logic [4:0] high_wr;
      logic [4:0] crit_wr;
      logic [15:0] row;
      logic [13:0] col;
      logic [1:0] chan;
      logic [1:0] dimm;
      logic [1:0] rank;
      logic [3:0] bank;
      logic running;
      logic done;
      logic [31:0] rdata;
      logic [2:0] avail;
      logic [2:0] wr_ok;
   } mcsr_state_s;

   mcsr_state_s state_reg;
   mcsr_state_s state_next;

   // One counter step: issue takes a credit, completion returns it
   function automatic logic [4:0] mcsr_step(input logic [4:0] cnt, input logic take, input logic give);
      logic [4:0] res;
      res = cnt;
      if (take && !give && cnt != 5'h00) begin
         res = cnt - 5'h01;
      end else if (give && !take && cnt != 5'h1f) begin
         res = cnt + 5'h01;
      end
      return res;
   endfunction

   logic wr_rd_credit;
   logic wr_thld;
   logic wr_lo;
   logic wr_hi;
   logic take_n;
   logic take_h;
   logic take_c;
   logic give_n;
   logic give_h;
   logic give_c;

   assign wr_rd_credit = cfg_wr_i && cfg_addr_i == MCSR_OFS_RD_CREDIT;
   assign wr_thld = cfg_wr_i && cfg_addr_i == MCSR_OFS_WR_THLD;
   assign wr_lo = cfg_wr_i && cfg_addr_i == MCSR_OFS_SCRUB_LO;
   assign wr_hi = cfg_wr_i && cfg_addr_i == MCSR_OFS_SCRUB_HI;
   // Issue blocked at zero credits
   assign take_n = rd_issue_i && rd_issue_class_i == MCSR_CLS_NORMAL && state_reg.avail[0];
   assign take_h = rd_issue_i && rd_issue_class_i == MCSR_CLS_HIGH && state_reg.avail[1];
   assign take_c = rd_issue_i && rd_issue_class_i == MCSR_CLS_CRIT && state_reg.avail[2];
   // Completion returns a credit to its own class only
   assign give_n = rd_done_i && rd_done_class_i == MCSR_CLS_NORMAL;
   assign give_h = rd_done_i && rd_done_class_i == MCSR_CLS_HIGH;
   assign give_c = rd_done_i && rd_done_class_i == MCSR_CLS_CRIT;

   always_comb begin
      state_next = state_reg;
      state_next.cnt_norm = mcsr_step(state_reg.cnt_norm, take_n, give_n);
      state_next.cnt_high = mcsr_step(state_reg.cnt_high, take_h, give_h);
      state_next.cnt_crit = mcsr_step(state_reg.cnt_crit, take_c, give_c);
      if (wr_rd_credit) begin
         // Reload drops outstanding accounting; software keeps the decoder idle
         state_next.crit_rd = cfg_wdata_i[MCSR_CRIT_RD_LSB +: 5];
         state_next.high_rd = cfg_wdata_i[MCSR_HIGH_RD_LSB +: 5];
         state_next.norm_rd = cfg_wdata_i[MCSR_NORM_RD_LSB +: 5];
         state_next.cnt_crit = cfg_wdata_i[MCSR_CRIT_RD_LSB +: 5];
         state_next.cnt_high = cfg_wdata_i[MCSR_HIGH_RD_LSB +: 5];
         state_next.cnt_norm = cfg_wdata_i[MCSR_NORM_RD_LSB +: 5];
      end
      if (wr_thld) begin
         state_next.high_wr = cfg_wdata_i[MCSR_HIGH_WR_LSB +: 5];
         state_next.crit_wr = cfg_wdata_i[MCSR_CRIT_WR_LSB +: 5];
      end
      // Software write first, hardware log wins on collision
      if (wr_lo) begin
         state_next.row = cfg_wdata_i[MCSR_ROW_LSB +: 16];
         state_next.col = cfg_wdata_i[MCSR_COL_LSB +: 14];
      end
      if (wr_hi) begin
         state_next.chan = cfg_wdata_i[MCSR_CHAN_LSB +: 2];
         state_next.dimm = cfg_wdata_i[MCSR_DIMM_LSB +: 2];
         state_next.rank = cfg_wdata_i[MCSR_RANK_LSB +: 2];
         state_next.bank = cfg_wdata_i[MCSR_BANK_LSB +: 4];
         if (cfg_wdata_i[MCSR_DONE_CLR_BIT]) begin
            state_next.done = 1'b0;
         end
      end
      if (scrub_issued_i || (test_running_i && test_error_i)) begin
         state_next.row = scrub_row_i;
         state_next.col = scrub_col_i;
         state_next.dimm = scrub_dimm_i;
         state_next.rank = scrub_rank_i;
         state_next.bank = scrub_bank_i;
      end
      state_next.running = test_running_i;
      if (test_complete_i) begin
         state_next.done = 1'b1;
      end
      state_next.avail = {state_next.cnt_crit != 5'h00, state_next.cnt_high != 5'h00,
                          state_next.cnt_norm != 5'h00};
      // Free write credits must exceed what higher classes reserve
      state_next.wr_ok = {wr_credits_free_i != 5'h00, wr_credits_free_i > state_next.crit_wr,
                          wr_credits_free_i > state_next.high_wr};
      state_next.rdata = 32'h0000_0000;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            MCSR_OFS_RD_CREDIT: begin
               state_next.rdata[MCSR_CRIT_RD_LSB +: 5] = state_reg.crit_rd;
               state_next.rdata[MCSR_HIGH_RD_LSB +: 5] = state_reg.high_rd;
               state_next.rdata[MCSR_NORM_RD_LSB +: 5] = state_reg.norm_rd;
            end
            MCSR_OFS_WR_THLD: begin
               state_next.rdata[MCSR_HIGH_WR_LSB +: 5] = state_reg.high_wr;
               state_next.rdata[MCSR_CRIT_WR_LSB +: 5] = state_reg.crit_wr;
            end
            MCSR_OFS_SCRUB_LO: begin
               state_next.rdata[MCSR_ROW_LSB +: 16] = state_reg.row;
               state_next.rdata[MCSR_COL_LSB +: 14] = state_reg.col;
            end
            MCSR_OFS_SCRUB_HI: begin
               state_next.rdata[MCSR_RUNNING_BIT] = state_reg.running;
               state_next.rdata[MCSR_DONE_BIT] = state_reg.done;
               state_next.rdata[MCSR_CHAN_LSB +: 2] = state_reg.chan;
               state_next.rdata[MCSR_DIMM_LSB +: 2] = state_reg.dimm;
               state_next.rdata[MCSR_RANK_LSB +: 2] = state_reg.rank;
               state_next.rdata[MCSR_BANK_LSB +: 4] = state_reg.bank;
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= '0;
         state_reg.crit_rd <= MCSR_CRIT_RD_RST;
         state_reg.high_rd <= MCSR_HIGH_RD_RST;
         state_reg.norm_rd <= MCSR_NORM_RD_RST;
         state_reg.cnt_crit <= MCSR_CRIT_RD_RST;
         state_reg.cnt_high <= MCSR_HIGH_RD_RST;
         state_reg.cnt_norm <= MCSR_NORM_RD_RST;
         state_reg.avail <= 3'h7;
         state_reg.high_wr <= MCSR_HIGH_WR_RST;
         state_reg.crit_wr <= MCSR_CRIT_WR_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cfg_rdata_o = state_reg.rdata;
   assign rd_credit_avail_o = state_reg.avail;
   assign wr_grant_ok_o = state_reg.wr_ok;
   assign next_scrub_low_o = {state_reg.row, state_reg.col};
   assign next_scrub_high_o = {state_reg.chan, state_reg.dimm, state_reg.rank, state_reg.bank};

endmodule

// File: mcsr_pkg.sv
package mcsr_pkg;
   localparam logic [7:0] MCSR_OFS_RD_CREDIT = 8'h70;
   localparam logic [7:0] MCSR_OFS_WR_THLD = 8'h74;
   localparam logic [7:0] MCSR_OFS_SCRUB_LO = 8'h78;
   localparam logic [7:0] MCSR_OFS_SCRUB_HI = 8'h7c;
   localparam int MCSR_CRIT_RD_LSB = 16;
   localparam int MCSR_HIGH_RD_LSB = 8;
   localparam int MCSR_NORM_RD_LSB = 0;
   localparam logic [4:0] MCSR_CRIT_RD_RST = 5'h03;
   localparam logic [4:0] MCSR_HIGH_RD_RST = 5'h01;
   localparam logic [4:0] MCSR_NORM_RD_RST = 5'h0d;
   localparam int MCSR_HIGH_WR_LSB = 8;
   localparam int MCSR_CRIT_WR_LSB = 0;
   localparam logic [4:0] MCSR_HIGH_WR_RST = 5'h04;
   localparam logic [4:0] MCSR_CRIT_WR_RST = 5'h03;
   localparam int MCSR_ROW_LSB = 14;
   localparam int MCSR_COL_LSB = 0;
   localparam int MCSR_RUNNING_BIT = 12;
   localparam int MCSR_DONE_BIT = 11;
   localparam int MCSR_DONE_CLR_BIT = 10;
   localparam int MCSR_CHAN_LSB = 8;
   localparam int MCSR_DIMM_LSB = 6;
   localparam int MCSR_RANK_LSB = 4;
   localparam int MCSR_BANK_LSB = 0;
   localparam logic [31:0] MCSR_ZERO_RST = 32'h0000_0000;
   // Read priority classes
   typedef enum logic [1:0] {
      MCSR_CLS_NORMAL = 2'b00,
      MCSR_CLS_HIGH = 2'b01,
      MCSR_CLS_CRIT = 2'b10
   } mcsr_class_e;
endpackage

// File: mcsr_regs_checker.sv
`timescale 1ns/1ps
module mcsr_regs_checker
   import mcsr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic rd_issue_i,
   input wire logic [1:0] rd_issue_class_i,
   input wire logic rd_done_i,
   input wire logic [2:0] rd_credit_avail_o,
   input wire logic [4:0] wr_credits_free_i,
   input wire logic [2:0] wr_grant_ok_o,
   input wire logic scrub_issued_i,
   input wire logic [15:0] scrub_row_i,
   input wire logic [13:0] scrub_col_i,
   input wire logic test_error_i,
   input wire logic test_running_i,
   input wire logic test_complete_i,
   input wire logic [29:0] next_scrub_low_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic crd_wr = cfg_wr_i && cfg_addr_i == MCSR_OFS_RD_CREDIT;
   wire logic hi_rd = cfg_rd_i && cfg_addr_i == MCSR_OFS_SCRUB_HI && !cfg_wr_i;
   AST_RDATA_IDLE: assert property (!$past(cfg_rd_i) |-> cfg_rdata_o == 32'h0)
      else $error("read data not idle");
   AST_WR_CRIT: assert property ($past(reset_n_i) |-> wr_grant_ok_o[2] == ($past(wr_credits_free_i) != 5'h0))
      else $error("critical write grant wrong");
   AST_CREDIT_LOAD: assert property (crd_wr && !rd_issue_i && !rd_done_i |=> rd_credit_avail_o ==
      {|$past(cfg_wdata_i[20:16]), |$past(cfg_wdata_i[12:8]), |$past(cfg_wdata_i[4:0])})
      else $error("credit reload wrong");
   AST_ISSUE_ONLY: assert property ($fell(rd_credit_avail_o[0]) |->
      $past(crd_wr || rd_issue_i && rd_issue_class_i == MCSR_CLS_NORMAL))
      else $error("normal credit lost without issue");
   AST_SCRUB_LOG: assert property (scrub_issued_i |=> next_scrub_low_o == {$past(scrub_row_i), $past(scrub_col_i)})
      else $error("scrub address not logged");
   AST_TEST_LOG: assert property (test_error_i && test_running_i |=>
      next_scrub_low_o == {$past(scrub_row_i), $past(scrub_col_i)})
      else $error("failing address not logged");
   AST_TEST_IGNORE: assert property (test_error_i && !test_running_i && !scrub_issued_i && !cfg_wr_i |=>
      $stable(next_scrub_low_o))
      else $error("error logged outside test");
   AST_DONE_SEEN: assert property (test_complete_i ##1 !cfg_wr_i ##1 hi_rd |=> cfg_rdata_o[MCSR_DONE_BIT])
      else $error("done not reported");
   cover property (scrub_issued_i);
   cover property (crd_wr);
   cover property (test_complete_i);
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
   import mcsr_pkg::*;
;
   logic clk_i = 1'h0, reset_n_i = 1'h0, cfg_wr_i = 1'h0, cfg_rd_i = 1'h0, rd_issue_i = 1'h0, rd_done_i = 1'h0;
   logic scrub_issued_i = 1'h0, test_error_i = 1'h0, test_running_i = 1'h0, test_complete_i = 1'h0;
   logic [7:0] cfg_addr_i = 8'h0;
   logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, seed = 32'h83fd, q, r, x;
   logic [1:0] rd_issue_class_i = 2'h0, rd_done_class_i = 2'h0, scrub_dimm_i = 2'h0, scrub_rank_i = 2'h0;
   logic [2:0] rd_credit_avail_o, wr_grant_ok_o;
   logic [4:0] wr_credits_free_i = 5'h0, h = 5'h4, c = 5'h3, f;
   logic [15:0] scrub_row_i = 16'h0;
   logic [13:0] scrub_col_i = 14'h0;
   logic [3:0] scrub_bank_i = 4'h0;
   logic [29:0] next_scrub_low_o;
   logic [9:0] next_scrub_high_o;
   int bad_count = 0, check_count = 0, cyc = 0;
   mcsr_regs i_mcsr_regs (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i),
      .cfg_addr_i(cfg_addr_i),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o),
      .rd_issue_i(rd_issue_i),
      .rd_issue_class_i(rd_issue_class_i),
      .rd_done_i(rd_done_i),
      .rd_done_class_i(rd_done_class_i),
      .rd_credit_avail_o(rd_credit_avail_o),
      .wr_credits_free_i(wr_credits_free_i),
      .wr_grant_ok_o(wr_grant_ok_o),
      .scrub_issued_i(scrub_issued_i),
      .scrub_row_i(scrub_row_i),
      .scrub_col_i(scrub_col_i),
      .scrub_dimm_i(scrub_dimm_i),
      .scrub_rank_i(scrub_rank_i),
      .scrub_bank_i(scrub_bank_i),
      .test_error_i(test_error_i),
      .test_running_i(test_running_i),
      .test_complete_i(test_complete_i),
      .next_scrub_low_o(next_scrub_low_o),
      .next_scrub_high_o(next_scrub_high_o)
   );
   always #2.5 clk_i = ~clk_i;
   task automatic finish_test();
      if (bad_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      check_count++;
      if (a !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, a, e);
      end
   endtask
`define CHK(a, e) chk(a, e)
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Critical needs any credit; lower classes must leave the reserve untouched
   function automatic logic [2:0] grant_exp(input logic [4:0] fr, input logic [4:0] cr, input logic [4:0] hr);
      return {fr != 5'h0, fr > cr, fr > hr};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cfg_wr_i, cfg_addr_i, cfg_wdata_i} <= {1'h1, a, d};
      @(posedge clk_i);
      cfg_wr_i <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      {cfg_rd_i, cfg_addr_i} <= {1'h1, a};
      @(posedge clk_i);
      cfg_rd_i <= 1'h0;
      #1 x = cfg_rdata_o;
   endtask
   // Issue when is_i is high, otherwise completion, of class c_i
   task automatic req(input logic is_i, input logic [1:0] c_i, input logic [2:0] e);
      @(posedge clk_i);
      {rd_issue_i, rd_done_i, rd_issue_class_i, rd_done_class_i} <= {is_i, !is_i, c_i, c_i};
      @(posedge clk_i);
      {rd_issue_i, rd_done_i} <= 2'h0;
      #1 `CHK(rd_credit_avail_o, e);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'h1;
      for (int i = 0; i < 5; i++) begin
         rd(8'h70 + 8'(4 * i));
         `CHK(x, i == 0 ? 32'h0003010d : i == 1 ? 32'h00000403 : 32'h0);
      end
      wr(8'h70, 32'h2);
      #1 `CHK(rd_credit_avail_o, 3'h1);
      req(1'h1, MCSR_CLS_NORMAL, 3'h1);
      req(1'h1, MCSR_CLS_NORMAL, 3'h0);
      req(1'h1, MCSR_CLS_NORMAL, 3'h0);
      req(1'h0, MCSR_CLS_NORMAL, 3'h1);
      req(1'h0, MCSR_CLS_NORMAL, 3'h1);
      wr(8'h70, 32'h00010203);
      #1 `CHK(rd_credit_avail_o, 3'h7);
      req(1'h1, MCSR_CLS_CRIT, 3'h3);
      req(1'h0, MCSR_CLS_CRIT, 3'h7);
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         if (i % 4 == 2) begin
            h = r[4:0] == 5'h1f ? 5'h1e : r[4:0];
            c = r[12:8] > h ? h : r[12:8];
            wr(8'h74, {19'h0, h, 3'h0, c});
         end
         f = i % 5 == 1 ? h : i % 5 == 3 ? c : r[20:16];
         @(posedge clk_i);
         wr_credits_free_i <= f;
         @(posedge clk_i);
         #1 `CHK(wr_grant_ok_o, grant_exp(f, c, h));
      end
      r = rnd();
      q = rnd();
      wr(8'h78, {2'h0, r[29:0]});
      wr(8'h7c, {22'h0, q[9:0]});
      rd(8'h78);
      `CHK(x, {2'h0, r[29:0]});
      rd(8'h7c);
      `CHK(x, {22'h0, q[9:0]});
      r = rnd();
      @(posedge clk_i);
      {scrub_issued_i, scrub_row_i, scrub_col_i, scrub_dimm_i, scrub_rank_i, scrub_bank_i} <= {1'h1, r[29:0], r[31:24]};
      @(posedge clk_i);
      scrub_issued_i <= 1'h0;
      #1 `CHK(next_scrub_low_o, r[29:0]);
      `CHK(next_scrub_high_o, {q[9:8], r[31:24]});
      r = rnd();
      @(posedge clk_i);
      {test_running_i, test_error_i, scrub_row_i, scrub_col_i} <= {2'h3, r[29:0]};
      @(posedge clk_i);
      test_error_i <= 1'h0;
      #1 `CHK(next_scrub_low_o, r[29:0]);
      rd(8'h7c);
      `CHK(x[12:10], 3'h4);
      @(posedge clk_i);
      {test_running_i, test_complete_i, test_error_i, scrub_row_i} <= {3'h3, ~r[29:14]};
      @(posedge clk_i);
      {test_complete_i, test_error_i} <= 2'h0;
      rd(8'h7c);
      `CHK({x[12:10], next_scrub_low_o}, {3'h2, r[29:0]});
      wr(8'h7c, 32'h0);
      rd(8'h7c);
      `CHK(x[12:10], 3'h2);
      wr(8'h7c, 32'h400);
      rd(8'h7c);
      `CHK(x[12:10], 3'h0);
      // Mid-run reset must restore credits and clear the scrub log
      @(posedge clk_i);
      reset_n_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'h1;
      #1 `CHK({19'h0, rd_credit_avail_o, next_scrub_high_o}, 32'h0000_1c00);
      `CHK({2'h0, next_scrub_low_o}, 32'h0);
      rd(8'h70);
      `CHK(x, 32'h0003010d);
      finish_test();
   end
endmodule
bind mcsr_regs mcsr_regs_checker i_mcsr_regs_checker (.*);
